/* File: core/irc_top.sv */
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module irc_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire irc_pkg::irc_pins_t ext_pins,
   input wire irc_pkg::irc_events_t events,
   input wire logic service_ack,
   input wire logic [2:0] service_src,
   output logic irq_request,
   output logic [2:0] irq_source,
   output logic wake_request,
   output logic irq
);
   typedef struct packed {
      irc_pkg::irc_bus_st_t bst;
      logic [31:0] rdata;
      logic [1:0] resp;
      logic [7:0] edge_sel;
      logic [7:0] pri;
      logic [7:0] sec;
      logic [7:0] grp_a;
      logic [7:0] grp_b;
      logic [6:0] evt;
      logic [6:0] mask;
      logic [6:0] flags_prev;
      logic wake;
   } irc_top_st_t;
   irc_top_st_t q, d;
   logic hit_a, hit_b;
   logic [6:0] flags, en, pend, hw_set;
   logic wr_go, rd_go;
   logic [2:0] pick;
   // ----------------------------------------
   // Pin edge detection
   // ----------------------------------------
   irc_edge_det u_edge_a (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(ext_pins.pin_a),
      .mode(q.edge_sel[irc_pkg::IRC_EDGE_A_LO +: 2]),
      .hit(hit_a)
   );
   irc_edge_det u_edge_b (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(ext_pins.pin_b),
      .mode(q.edge_sel[irc_pkg::IRC_EDGE_B_LO +: 2]),
      .hit(hit_b)
   );
   // ----------------------------------------
   // Flag and enable views
   // ----------------------------------------
   assign flags = {q.pri[irc_pkg::IRC_GRP_B_FLAG], q.pri[irc_pkg::IRC_GRP_A_FLAG], q.sec[irc_pkg::IRC_TB_B_FLAG],
                   q.sec[irc_pkg::IRC_TB_A_FLAG], q.sec[irc_pkg::IRC_CONV_FLAG], q.sec[irc_pkg::IRC_PIN_B_FLAG],
                   q.pri[irc_pkg::IRC_PIN_A_FLAG]};
   assign en = {q.pri[irc_pkg::IRC_GRP_B_EN], q.pri[irc_pkg::IRC_GRP_A_EN], q.sec[irc_pkg::IRC_TB_B_EN],
                q.sec[irc_pkg::IRC_TB_A_EN], q.sec[irc_pkg::IRC_CONV_EN], q.sec[irc_pkg::IRC_PIN_B_EN],
                q.pri[irc_pkg::IRC_PIN_A_EN]};
   assign pend = flags & en & {irc_pkg::IRC_NSRC{q.pri[irc_pkg::IRC_GLOBAL_EN]}};
   // Lowest index has priority
   always_comb begin
      pick = irc_pkg::IRC_SRC_NONE;
      for (int i = irc_pkg::IRC_NSRC - 1; i >= 0; i--) begin
         if (pend[i]) begin
            pick = 3'(i);
         end
      end
   end
   assign irq_request = |pend;
   assign irq_source = pick;
   assign wake_request = q.wake;
   assign irq = |(q.evt & q.mask);
   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   assign wr_go = (q.bst == irc_pkg::IRC_B_IDLE) && s_axi_awvalid && s_axi_wvalid;
   assign rd_go = (q.bst == irc_pkg::IRC_B_IDLE) && s_axi_arvalid && !wr_go;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid = (q.bst == irc_pkg::IRC_B_WRESP);
   assign s_axi_rvalid = (q.bst == irc_pkg::IRC_B_RRESP);
   assign s_axi_bresp = q.resp;
   assign s_axi_rresp = q.resp;
   assign s_axi_rdata = q.rdata;
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d = q;
      hw_set = '0;
      // Hardware sets
      hw_set[0] = hit_a;
      hw_set[1] = hit_b;
      hw_set[2] = events.conv_done;
      hw_set[3] = events.tb_a;
      hw_set[4] = events.tb_b;
      if (events.tmr_s_match_a) d.grp_a[irc_pkg::IRC_MATCH_A_FLAG] = 1'b1;
      if (events.tmr_s_match_p) d.grp_a[irc_pkg::IRC_MATCH_P_FLAG] = 1'b1;
      if (events.tmr_p_match_a) d.grp_b[irc_pkg::IRC_MATCH_A_FLAG] = 1'b1;
      if (events.tmr_p_match_p) d.grp_b[irc_pkg::IRC_MATCH_P_FLAG] = 1'b1;
      hw_set[5] = |(q.grp_a[irc_pkg::IRC_FLAG_OFS +: 2] & q.grp_a[1:0]);
      hw_set[6] = |(q.grp_b[irc_pkg::IRC_FLAG_OFS +: 2] & q.grp_b[1:0]);
      // Servicing clears flag and global enable
      if (service_ack) begin
         d.pri[irc_pkg::IRC_GLOBAL_EN] = 1'b0;
         case (service_src)
            3'h0: d.pri[irc_pkg::IRC_PIN_A_FLAG] = 1'b0;
            3'h1: d.sec[irc_pkg::IRC_PIN_B_FLAG] = 1'b0;
            3'h2: d.sec[irc_pkg::IRC_CONV_FLAG] = 1'b0;
            3'h3: d.sec[irc_pkg::IRC_TB_A_FLAG] = 1'b0;
            3'h4: d.sec[irc_pkg::IRC_TB_B_FLAG] = 1'b0;
            3'h5: d.pri[irc_pkg::IRC_GRP_A_FLAG] = 1'b0;
            3'h6: d.pri[irc_pkg::IRC_GRP_B_FLAG] = 1'b0;
            default: d.pri = d.pri;
         endcase
      end
      // Hardware set wins over a same-cycle service clear
      if (hw_set[0]) d.pri[irc_pkg::IRC_PIN_A_FLAG] = 1'b1;
      if (hw_set[1]) d.sec[irc_pkg::IRC_PIN_B_FLAG] = 1'b1;
      if (hw_set[2]) d.sec[irc_pkg::IRC_CONV_FLAG] = 1'b1;
      if (hw_set[3]) d.sec[irc_pkg::IRC_TB_A_FLAG] = 1'b1;
      if (hw_set[4]) d.sec[irc_pkg::IRC_TB_B_FLAG] = 1'b1;
      if (hw_set[5]) d.pri[irc_pkg::IRC_GRP_A_FLAG] = 1'b1;
      if (hw_set[6]) d.pri[irc_pkg::IRC_GRP_B_FLAG] = 1'b1;
      // Wake on any newly set flag, enabled or not
      d.wake = |(flags & ~q.flags_prev);
      d.flags_prev = flags;
      d.evt = q.evt | (flags & ~q.flags_prev);
      // Bus
      case (q.bst)
         irc_pkg::IRC_B_IDLE: begin
            if (wr_go) begin
               d.bst = irc_pkg::IRC_B_WRESP;
               d.resp = 2'h0;
               if (s_axi_wstrb[0]) begin
                  if (s_axi_awaddr == irc_pkg::IRC_OFF_EDGE) begin
                     d.edge_sel = s_axi_wdata[7:0] & irc_pkg::IRC_EDGE_MASK;
                  end else if (s_axi_awaddr == irc_pkg::IRC_OFF_PRI) begin
                     d.pri = s_axi_wdata[7:0] & irc_pkg::IRC_PRI_MASK;
                  end else if (s_axi_awaddr == irc_pkg::IRC_OFF_SEC) begin
                     d.sec = s_axi_wdata[7:0];
                  end else if (s_axi_awaddr == irc_pkg::IRC_OFF_GRPA) begin
                     d.grp_a = s_axi_wdata[7:0] & irc_pkg::IRC_GRP_MASK;
                  end else if (s_axi_awaddr == irc_pkg::IRC_OFF_GRPB) begin
                     d.grp_b = s_axi_wdata[7:0] & irc_pkg::IRC_GRP_MASK;
                  end else if (s_axi_awaddr == irc_pkg::IRC_OFF_MASK) begin
                     d.mask = s_axi_wdata[6:0];
                  end else if (s_axi_awaddr != irc_pkg::IRC_OFF_EVT) begin
                     d.resp = 2'h2;
                  end
               end
            end else if (rd_go) begin
               d.bst = irc_pkg::IRC_B_RRESP;
               d.resp = 2'h0;
               d.rdata = '0;
               if (s_axi_araddr == irc_pkg::IRC_OFF_EDGE) begin
                  d.rdata[7:0] = q.edge_sel;
               end else if (s_axi_araddr == irc_pkg::IRC_OFF_PRI) begin
                  d.rdata[7:0] = q.pri;
               end else if (s_axi_araddr == irc_pkg::IRC_OFF_SEC) begin
                  d.rdata[7:0] = q.sec;
               end else if (s_axi_araddr == irc_pkg::IRC_OFF_GRPA) begin
                  d.rdata[7:0] = q.grp_a;
               end else if (s_axi_araddr == irc_pkg::IRC_OFF_GRPB) begin
                  d.rdata[7:0] = q.grp_b;
               end else if (s_axi_araddr == irc_pkg::IRC_OFF_EVT) begin
                  d.rdata[6:0] = q.evt;
                  d.evt = flags & ~q.flags_prev;
               end else if (s_axi_araddr == irc_pkg::IRC_OFF_MASK) begin
                  d.rdata[6:0] = q.mask;
               end else begin
                  d.resp = 2'h2;
               end
            end
         end
         irc_pkg::IRC_B_WRESP: begin
            if (s_axi_bready) d.bst = irc_pkg::IRC_B_IDLE;
         end
         irc_pkg::IRC_B_RRESP: begin
            if (s_axi_rready) d.bst = irc_pkg::IRC_B_IDLE;
         end
         default: d.bst = irc_pkg::IRC_B_IDLE;
      endcase
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.bst <= irc_pkg::IRC_B_IDLE;
      end else begin
         q <= d;
      end
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_service_clears_ge: assert property (@(posedge aclk) disable iff (!aresetn)
      service_ack && !wr_go |=> !q.pri[irc_pkg::IRC_GLOBAL_EN])
      else $error("global enable not cleared");
   chk_no_irq_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
      !q.pri[irc_pkg::IRC_GLOBAL_EN] |-> !irq_request && irq_source == irc_pkg::IRC_SRC_NONE)
      else $error("request while disabled");
   chk_conv_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      events.conv_done && !wr_go |=> q.sec[irc_pkg::IRC_CONV_FLAG])
      else $error("conv flag missing");
   chk_edge_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      q.edge_sel[7:4] == 4'h0)
      else $error("edge high bits set");
   chk_pri_bit7: assert property (@(posedge aclk) disable iff (!aresetn)
      !q.pri[7])
      else $error("primary bit 7 set");
   chk_grp_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      hw_set[5] && !wr_go |=> q.pri[irc_pkg::IRC_GRP_A_FLAG])
      else $error("group flag missing");
   chk_grp_b_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      hw_set[6] && !wr_go |=> q.pri[irc_pkg::IRC_GRP_B_FLAG])
      else $error("group b flag missing");
   chk_wake_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(q.sec[irc_pkg::IRC_TB_A_FLAG]) |=> wake_request)
      else $error("no wake");
   chk_sw_wins: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && s_axi_wstrb[0] && s_axi_awaddr == irc_pkg::IRC_OFF_SEC |=> q.sec == $past(s_axi_wdata[7:0]))
      else $error("write lost");
   chk_pri_write: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && s_axi_wstrb[0] && s_axi_awaddr == irc_pkg::IRC_OFF_PRI
      |=> q.pri == ($past(s_axi_wdata[7:0]) & irc_pkg::IRC_PRI_MASK))
      else $error("primary write lost");
   chk_pin_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      hit_a && !wr_go |=> q.pri[irc_pkg::IRC_PIN_A_FLAG])
      else $error("pin flag missing");
   chk_pin_b_edge: assert property (@(posedge aclk) disable iff (!aresetn)
      hit_b && !wr_go |=> q.sec[irc_pkg::IRC_PIN_B_FLAG])
      else $error("pin b flag missing");
   chk_tb_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      events.tb_a && !wr_go |=> q.sec[irc_pkg::IRC_TB_A_FLAG])
      else $error("time base flag missing");
   chk_match_sets: assert property (@(posedge aclk) disable iff (!aresetn)
      events.tmr_p_match_p && !wr_go |=> q.grp_b[irc_pkg::IRC_MATCH_P_FLAG])
      else $error("match flag missing");
   chk_grp_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
      (q.grp_a & ~irc_pkg::IRC_GRP_MASK) == 8'h00 && (q.grp_b & ~irc_pkg::IRC_GRP_MASK) == 8'h00)
      else $error("group reserved bits set");
   chk_service_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      service_ack && service_src == 3'h3 && !events.tb_a && !wr_go |=> !q.sec[irc_pkg::IRC_TB_A_FLAG])
      else $error("serviced flag kept");
   chk_flags_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !wr_go && !service_ack && hw_set == 7'h00 |=> flags == $past(flags))
      else $error("flag changed without cause");
   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   cov_write: cover property (@(posedge aclk) wr_go);
   cov_read: cover property (@(posedge aclk) rd_go);
   cov_service: cover property (@(posedge aclk) irq_request ##1 service_ack);
   cov_irq: cover property (@(posedge aclk) irq);
   cov_pin_edge: cover property (@(posedge aclk) hit_a || hit_b);
endmodule
`default_nettype wire

/* File: common/irc_pkg.sv */
// How it works
// - Two pins plus timer, converter, time-base sources
// - Edge bits 3:2 select pin B trigger
// - Edge bits 1:0 select pin A trigger
// - Edge register bits 7:4 read zero
// - Primary bit 0 is global enable
// - Primary bits 6,5 hold group flags
// - Primary bit 4 pin A flag, bit 1 enable
// - Primary bits 3,2 hold group enables
// - Primary bit 7 reads zero
// - Secondary bit 6 pin B flag, bit 2 enable
// - Secondary bits 5,4 time-base flags, 1,0 enables
// - Flag one means pending; enable one permits
// - Group sources: match flags 5,4, enables 1,0
// - Group flag set by enabled source flag
// - Service clears flag and global enable
// - Any newly set source flag raises wake request for one cycle
package irc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] IRC_OFF_EDGE = 8'h00;
   localparam logic [7:0] IRC_OFF_PRI = 8'h04;
   localparam logic [7:0] IRC_OFF_SEC = 8'h08;
   localparam logic [7:0] IRC_OFF_GRPA = 8'h0C;
   localparam logic [7:0] IRC_OFF_GRPB = 8'h10;
   localparam logic [7:0] IRC_OFF_EVT = 8'h14;
   localparam logic [7:0] IRC_OFF_MASK = 8'h18;
   localparam logic [7:0] IRC_RESET_VAL = 8'h00;
   localparam logic [7:0] IRC_EDGE_MASK = 8'h0F;
   localparam logic [7:0] IRC_PRI_MASK = 8'h7F;
   localparam logic [7:0] IRC_GRP_MASK = 8'h33;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int IRC_GLOBAL_EN = 0;
   localparam int IRC_PIN_A_EN = 1;
   localparam int IRC_GRP_A_EN = 2;
   localparam int IRC_GRP_B_EN = 3;
   localparam int IRC_PIN_A_FLAG = 4;
   localparam int IRC_GRP_A_FLAG = 5;
   localparam int IRC_GRP_B_FLAG = 6;
   localparam int IRC_TB_A_EN = 0;
   localparam int IRC_TB_B_EN = 1;
   localparam int IRC_PIN_B_EN = 2;
   localparam int IRC_CONV_EN = 3;
   localparam int IRC_TB_A_FLAG = 4;
   localparam int IRC_TB_B_FLAG = 5;
   localparam int IRC_PIN_B_FLAG = 6;
   localparam int IRC_CONV_FLAG = 7;
   localparam int IRC_MATCH_P_EN = 0;
   localparam int IRC_MATCH_A_EN = 1;
   localparam int IRC_MATCH_P_FLAG = 4;
   localparam int IRC_MATCH_A_FLAG = 5;
   localparam int IRC_FLAG_OFS = 4;
   localparam int IRC_EDGE_A_LO = 0;
   localparam int IRC_EDGE_B_LO = 2;
   // Source index: 0 pin A, 1 pin B, 2 conv, 3 tb A, 4 tb B, 5 grp A, 6 grp B
   localparam int IRC_NSRC = 7;
   localparam logic [2:0] IRC_SRC_NONE = 3'h7;
   typedef enum logic [1:0] {
      IRC_EDGE_OFF = 2'h0,
      IRC_EDGE_RISE = 2'h1,
      IRC_EDGE_FALL = 2'h2,
      IRC_EDGE_BOTH = 2'h3
   } irc_edge_t;
   typedef enum logic [2:0] {
      IRC_B_IDLE = 3'h1,
      IRC_B_WRESP = 3'h2,
      IRC_B_RRESP = 3'h4
   } irc_bus_st_t;
   typedef struct packed {
      logic pin_a;
      logic pin_b;
   } irc_pins_t;
   typedef struct packed {
      logic conv_done;
      logic tb_a;
      logic tb_b;
      logic tmr_s_match_a;
      logic tmr_s_match_p;
      logic tmr_p_match_a;
      logic tmr_p_match_p;
   } irc_events_t;
endpackage

/* File: core/irc_edge_det.sv */
`timescale 1ns/1ns
`default_nettype none
module irc_edge_det (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   input wire logic [1:0] mode,
   output logic hit
);
   typedef struct packed {
      logic [2:0] sync;
      logic level;
   } irc_edge_st_t;
   irc_edge_st_t q, d;
   always_comb begin
      d = q;
      d.sync = {q.sync[1:0], pin};
      hit = 1'b0;
      if (q.sync[2] == q.sync[1]) begin
         d.level = q.sync[2];
         if (q.sync[2] && !q.level) begin
            hit = mode[0];
         end else if (!q.sync[2] && q.level) begin
            hit = mode[1];
         end
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

/* File: bench/irc_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Core model: takes pending requests after a delay
// ----------------------------------------
module irc_core_model (
   input wire logic aclk,
   input wire logic enable,
   input wire logic [3:0] delay,
   input wire logic irq_request,
   input wire logic [2:0] irq_source,
   output logic service_ack,
   output logic [2:0] service_src,
   output var int served,
   output logic [2:0] last_src
);
   logic [2:0] s;
   initial begin
      service_ack = 1'h0;
      service_src = 3'h0;
      served = 0;
      last_src = 3'h7;
   end
   always begin
      @(negedge aclk);
      if (enable && irq_request) begin
         repeat (delay) @(negedge aclk);
         if (irq_request) begin
            s = irq_source;
            @(posedge aclk);
            service_ack <= 1'h1;
            service_src <= s;
            @(posedge aclk);
            service_ack <= 1'h0;
            service_src <= ~s;
            served = served + 1;
            last_src = s;
         end
      end
   end
endmodule
`default_nettype wire

/* File: bench/test_interrupt_request_control.sv */
`timescale 1ns/1ns
`default_nettype none
module test_interrupt_request_control;
   logic aclk, aresetn, awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry;
   logic ack, irq_req, wake, irq, cen;
   logic [7:0] awa, ara, a;
   logic [31:0] wd, rd, d, g0, g1, p, s, e;
   logic [3:0] ws, dly;
   logic [1:0] br, rr, r, wresp;
   logic [2:0] src, irq_src, last_src;
   irc_pkg::irc_pins_t pins;
   irc_pkg::irc_events_t ev;
   int n_errors, n_tests, n_wake, served, cyc, w0, s0, fb, t, i, k, m, pn, g, j;
   irc_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
      .ext_pins(pins), .events(ev), .service_ack(ack), .service_src(src), .irq_request(irq_req),
      .irq_source(irq_src), .wake_request(wake), .irq(irq));
   irc_core_model i_core (.aclk(aclk), .enable(cen), .delay(dly), .irq_request(irq_req),
      .irq_source(irq_src), .service_ack(ack), .service_src(src), .served(served), .last_src(last_src));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] gact(input logic [31:0] v);
      return {31'h0, (v[5] & v[1]) | (v[4] & v[0])};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic bus_wr(input logic [7:0] ad, input logic [31:0] dv, input logic [3:0] sb = 4'hF);
      logic ta, tw, tb;
      @(posedge aclk);
      awa <= ad;
      wd <= dv;
      ws <= sb;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      do begin
         @(negedge aclk);
         ta = awv & awr;
         tw = wv & wrd;
         tb = bv & bry;
         wresp = br;
         @(posedge aclk);
         if (ta) awv <= 1'h0;
         if (tw) wv <= 1'h0;
      end while (!tb);
      bry <= 1'h0;
   endtask
   task automatic bus_rd(input logic [7:0] ad, output logic [31:0] dv, output logic [1:0] rs);
      logic ta, tb;
      @(posedge aclk);
      ara <= ad;
      arv <= 1'h1;
      rry <= 1'h1;
      do begin
         @(negedge aclk);
         ta = arv & arr;
         tb = rv & rry;
         dv = rd;
         rs = rr;
         @(posedge aclk);
         if (ta) arv <= 1'h0;
      end while (!tb);
      rry <= 1'h0;
   endtask
   task automatic rc(input logic [7:0] ad, input logic [31:0] exp);
      bus_rd(ad, d, r);
      check(d, exp);
   endtask
   task automatic pulse(input logic [6:0] b);
      @(posedge aclk);
      ev <= b;
      @(posedge aclk);
      ev <= 7'h0;
   endtask
   task automatic serve(input logic [31:0] pv, input logic [2:0] exp);
      s0 = served;
      bus_wr(irc_pkg::IRC_OFF_PRI, pv);
      for (t = 0; t < 40 && served == s0; t++) @(posedge aclk);
      check(served - s0, 1);
      check(last_src, exp);
   endtask
   // ----------------------------------------
   // Clock and timeout
   // ----------------------------------------
   initial begin
      aclk = 1'h0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (wake) n_wake++;
      if (cyc == 30000) begin
         n_errors++;
         print_verdict();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      {aresetn, awv, wv, bry, arv, rry, cen} = 7'h0;
      {awa, ara, wd, ws, dly, pins, ev} = 65'h0;
      void'($urandom(32'h5174));
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      for (i = 0; i < 7; i++) rc(8'(4 * i), 32'h0);
      bus_rd(8'h1C, d, r);
      check({30'h0, r}, 32'h2);
      bus_wr(8'h1C, 32'h0);
      check({30'h0, wresp}, 32'h2);
      repeat (4) begin
         {g0, g1, p, s, e} = {$urandom, $urandom, $urandom, $urandom, $urandom};
         bus_wr(irc_pkg::IRC_OFF_GRPA, g0);
         bus_wr(irc_pkg::IRC_OFF_GRPB, g1);
         bus_wr(irc_pkg::IRC_OFF_EDGE, e);
         bus_wr(irc_pkg::IRC_OFF_SEC, s);
         bus_wr(irc_pkg::IRC_OFF_PRI, p);
         bus_wr(irc_pkg::IRC_OFF_PRI, ~p, 4'h0);
         check({30'h0, wresp}, 32'h0);
         rc(irc_pkg::IRC_OFF_EDGE, e & 32'hF);
         rc(irc_pkg::IRC_OFF_SEC, s & 32'hFF);
         rc(irc_pkg::IRC_OFF_GRPA, g0 & 32'h33);
         rc(irc_pkg::IRC_OFF_GRPB, g1 & 32'h33);
         rc(irc_pkg::IRC_OFF_PRI, (p & 32'h7F) | (gact(g0) << 5) | (gact(g1) << 6));
         for (i = 0; i < 5; i++) bus_wr(8'(16 - 4 * i), 32'h0);
      end
      bus_rd(irc_pkg::IRC_OFF_EVT, d, r);
      for (pn = 0; pn < 2; pn++) for (m = 0; m < 4; m++) begin
         bus_wr(irc_pkg::IRC_OFF_EDGE, m << (2 * pn));
         w0 = n_wake;
         a = pn ? irc_pkg::IRC_OFF_SEC : irc_pkg::IRC_OFF_PRI;
         for (k = 0; k < 2; k++) begin
            @(posedge aclk);
            if (pn == 0) pins.pin_a <= (k == 0);
            else pins.pin_b <= (k == 0);
            repeat (8) @(posedge aclk);
            bus_rd(a, d, r);
            check(d[pn ? 6 : 4], m[k]);
            bus_wr(a, 32'h0);
         end
         check(n_wake - w0, m[0] + m[1]);
      end
      rc(irc_pkg::IRC_OFF_EVT, 32'h3);
      cen <= 1'h1;
      for (k = 2; k < 5; k++) begin
         fb = k == 2 ? 7 : k + 1;
         dly <= 4'($urandom % 8);
         bus_wr(irc_pkg::IRC_OFF_SEC, 1 << (fb - 4));
         pulse(7'(1 << (8 - k)));
         rc(irc_pkg::IRC_OFF_SEC, (1 << fb) | (1 << (fb - 4)));
         serve(32'h1, 3'(k));
         rc(irc_pkg::IRC_OFF_SEC, 1 << (fb - 4));
         rc(irc_pkg::IRC_OFF_PRI, 32'h0);
         bus_wr(irc_pkg::IRC_OFF_SEC, 32'h0);
      end
      for (g = 0; g < 2; g++) for (j = 0; j < 2; j++) begin
         a = irc_pkg::IRC_OFF_GRPA + 8'(4 * g);
         bus_wr(a, 32'h2 >> j);
         bus_wr(irc_pkg::IRC_OFF_PRI, 32'h4 << g);
         pulse(7'(8 >> (2 * g + j)));
         rc(a, 32'h22 >> j);
         rc(irc_pkg::IRC_OFF_PRI, 32'h24 << g);
         serve((32'h24 << g) | 32'h1, 3'(5 + g));
         rc(irc_pkg::IRC_OFF_PRI, 32'h24 << g);
         bus_wr(a, 32'h0);
         bus_wr(irc_pkg::IRC_OFF_PRI, 32'h0);
         rc(irc_pkg::IRC_OFF_PRI, 32'h0);
      end
      fork
         bus_wr(irc_pkg::IRC_OFF_SEC, 32'h0);
         pulse(7'h10);
      join
      rc(irc_pkg::IRC_OFF_SEC, 32'h0);
      bus_rd(irc_pkg::IRC_OFF_EVT, d, r);
      bus_wr(irc_pkg::IRC_OFF_MASK, 32'h4);
      pulse(7'h40);
      repeat (2) @(negedge aclk);
      check(irq, 1'h1);
      rc(irc_pkg::IRC_OFF_EVT, 32'h4);
      @(negedge aclk);
      check(irq, 1'h0);
      pulse(7'h20);
      repeat (2) @(negedge aclk);
      check(irq, 1'h0);
      rc(irc_pkg::IRC_OFF_EVT, 32'h8);
      print_verdict();
   end
endmodule
`default_nettype wire
